// ---- logic/osd_pkg.sv ----
/*
  constants, register map and carrier types of the octal serial driver
  control block.
  assumes a 40 MHz system clock and an AHB-Lite register bus of 32 bits.
*/
package osd_pkg;

  localparam int OSD_CH = 8;

  // timing
  localparam int OSD_CLK_PERIOD_PS = 25000;
  localparam int OSD_FAULT_DELAY_US = 160;
  localparam int OSD_FAULT_DELAY_CYC =
    (OSD_FAULT_DELAY_US * 1000000 + OSD_CLK_PERIOD_PS - 1) /
    OSD_CLK_PERIOD_PS;
  localparam int OSD_TMR_W = 16;

  // register byte offsets
  localparam logic [3:0] OSD_OFS_CTRL = 4'h0;
  localparam logic [3:0] OSD_OFS_STAT = 4'h4;
  localparam logic [3:0] OSD_OFS_DIAG = 4'h8;
  localparam logic [3:0] OSD_OFS_FLT  = 4'hc;
  localparam int OSD_ADDR_W = 4;

  // control fields
  localparam int OSD_CTRL_FLT_EN = 0;
  localparam int OSD_CTRL_CLR    = 1;
  localparam logic OSD_FLT_EN_RST = 1'b1;

  // status fields
  localparam int OSD_STAT_BUSY = 8;
  localparam int OSD_STAT_ACT  = 9;

  // diagnostic fields
  localparam int OSD_DIAG_WORD = 8;

  localparam logic [1:0] OSD_HTRANS_NONSEQ = 2'h2;
  localparam logic       OSD_HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    logic [OSD_ADDR_W-1:0] addr;
  } osd_bus_req_type;

endpackage

// ---- logic/osd_ctrl.sv ----
/*
  serial control and diagnostic logic of an eight-channel low-side driver:
  select-framed shift register on the shift clock, output latch with
  per-channel fault clearing, and an AHB-Lite register slave.
  assumes the host keeps the shift clock low around select edges and
  honours the select lead and lag times; sense inputs are asynchronous.
*/
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module osd_ctrl
  import osd_pkg::*;
#(
  parameter int unsigned FAULT_DELAY_CYC = OSD_FAULT_DELAY_CYC
)
(
  // system clock and reset
  input  wire logic              CLK,
  input  wire logic              CLK_EN,
  input  wire logic              RST,
  // ahb-lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic                   HREADYOUT,
  output logic [31:0]            HRDATA,
  output logic                   HRESP,
  // serial link
  input  wire logic              SPI_SCLK,
  input  wire logic              SPI_CE_N,
  input  wire logic              SPI_SI,
  output logic                   SPI_SO,
  output logic                   SPI_SO_OE,
  // output stages
  input  wire logic              RESET_PIN_N,
  input  wire logic [OSD_CH-1:0] SENSE,
  output logic [OSD_CH-1:0]      DRV_ON
);

  //--------------------------------------------------------------
  // input synchronisers
  //--------------------------------------------------------------
  logic [1:0]        ce_sync_r;
  logic [1:0]        rst_sync_r;
  logic [OSD_CH-1:0] sense_a_r;
  logic [OSD_CH-1:0] sense_s_r;
  logic              ce_low_d_r;
  logic              ce_low;
  logic              pin_rst;
  logic              ce_fall;
  logic              ce_rise;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ce_sync_r  <= 2'h3;
      rst_sync_r <= 2'h0;
      sense_a_r  <= '0;
      sense_s_r  <= '0;
    end
    else if (CLK_EN)
    begin
      ce_sync_r  <= {ce_sync_r[0], SPI_CE_N};
      rst_sync_r <= {rst_sync_r[0], RESET_PIN_N};
      sense_a_r  <= SENSE;
      sense_s_r  <= sense_a_r;
    end
  end

  assign ce_low  = ~ce_sync_r[1];
  assign pin_rst = ~rst_sync_r[1];
  assign ce_fall = ce_low & ~ce_low_d_r;
  assign ce_rise = ~ce_low & ce_low_d_r;

  always_ff @(posedge CLK)
  begin
    if (RST)
      ce_low_d_r <= 1'b0;
    else if (CLK_EN)
      ce_low_d_r <= ce_low;
  end

  //--------------------------------------------------------------
  // frame start: snapshot of sensed levels
  //--------------------------------------------------------------
  logic [OSD_CH-1:0] snap_r;
  logic              fid_r;
  logic              act_r;

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      snap_r <= '0;
      fid_r  <= 1'b0;
    end
    else if (CLK_EN && ce_fall)
    begin
      snap_r <= sense_s_r;
      fid_r  <= ~fid_r;
    end
  end

  // gates the shift clock domain; stable across a frame
  always_ff @(posedge CLK)
  begin
    if (RST)
      act_r <= 1'b0;
    else if (CLK_EN)
      act_r <= ce_low;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      SPI_SO_OE <= 1'b0;
    else if (CLK_EN)
      SPI_SO_OE <= ce_low;
  end

  //--------------------------------------------------------------
  // shift clock domain
  //--------------------------------------------------------------
  logic [OSD_CH-1:0] sh_r;
  logic              fid_seen_r;
  logic              shifted;

  // first falling edge of a frame merges the snapshot with the input bit
  assign shifted = (fid_seen_r == fid_r);

  always_ff @(negedge SPI_SCLK)
  begin
    if (act_r)
    begin
      fid_seen_r <= fid_r;
      if (shifted)
        sh_r <= {sh_r[OSD_CH-2:0], SPI_SI};
      else
        sh_r <= {snap_r[OSD_CH-2:0], SPI_SI};
    end
  end

  // if/else so an unknown frame tag at start-up still picks the snapshot
  always_ff @(posedge SPI_SCLK)
  begin
    if (act_r)
    begin
      if (shifted)
        SPI_SO <= sh_r[OSD_CH-1];
      else
        SPI_SO <= snap_r[OSD_CH-1];
    end
  end

  //--------------------------------------------------------------
  // output latch and fault inhibit timer
  //--------------------------------------------------------------
  logic [OSD_CH-1:0]    word_r;
  logic [OSD_TMR_W-1:0] tmr_r;
  logic                 busy_r;
  logic                 flt_en_r;
  logic                 soft_clr;
  logic [OSD_CH-1:0]    fault_hit;
  logic [OSD_CH-1:0]    frame_word;

  // shift clock is parked low after a frame, so these are quasi-static
  assign frame_word = shifted ? sh_r : snap_r;
  assign fault_hit  = (busy_r || !flt_en_r) ? '0 : (DRV_ON & sense_s_r);

  always_ff @(posedge CLK)
  begin
    if (RST)
      word_r <= '0;
    else if (CLK_EN && ce_rise)
      word_r <= frame_word;
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      DRV_ON <= '0;
    else if (CLK_EN)
    begin
      if (pin_rst || soft_clr)
        DRV_ON <= '0;
      else if (ce_rise)
        DRV_ON <= ~frame_word;
      else
        DRV_ON <= DRV_ON & ~fault_hit;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      tmr_r  <= '0;
      busy_r <= 1'b0;
    end
    else if (CLK_EN)
    begin
      if (ce_rise)
      begin
        tmr_r  <= OSD_TMR_W'(FAULT_DELAY_CYC - 1);
        busy_r <= 1'b1;
      end
      else if (tmr_r != '0)
        tmr_r <= tmr_r - 1'b1;
      else
        busy_r <= 1'b0;
    end
  end

  //--------------------------------------------------------------
  // ahb-lite slave
  //--------------------------------------------------------------
  osd_bus_req_type   req_r;
  logic [OSD_CH-1:0] flt_r;
  logic              take;
  logic              wr_hit;

  assign take   = HSEL && HREADY && (HTRANS == OSD_HTRANS_NONSEQ);
  assign wr_hit = req_r.valid && req_r.write;
  assign soft_clr = wr_hit && (req_r.addr == OSD_OFS_CTRL) &&
                    HWDATA[OSD_CTRL_CLR];

  function automatic logic [31:0] rd_mux(input logic [OSD_ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      OSD_OFS_CTRL: v[OSD_CTRL_FLT_EN] = flt_en_r;
      OSD_OFS_STAT:
      begin
        v[OSD_CH-1:0]    = DRV_ON;
        v[OSD_STAT_BUSY] = busy_r;
        v[OSD_STAT_ACT]  = act_r;
      end
      OSD_OFS_DIAG:
      begin
        v[OSD_CH-1:0]                      = snap_r;
        v[OSD_DIAG_WORD+:OSD_CH]           = word_r;
      end
      OSD_OFS_FLT:  v[OSD_CH-1:0] = flt_r;
      default:      v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      req_r     <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= OSD_HRESP_OKAY;
    end
    else if (CLK_EN)
    begin
      req_r.valid <= take;
      req_r.write <= HWRITE;
      req_r.addr  <= HADDR[OSD_ADDR_W-1:0];
      if (take && !HWRITE)
        HRDATA <= rd_mux(HADDR[OSD_ADDR_W-1:0]);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      flt_en_r <= OSD_FLT_EN_RST;
    else if (CLK_EN && wr_hit && req_r.addr == OSD_OFS_CTRL)
      flt_en_r <= HWDATA[OSD_CTRL_FLT_EN];
  end

  // sticky fault flags, write one to clear; a new fault wins the clear
  always_ff @(posedge CLK)
  begin
    if (RST)
      flt_r <= '0;
    else if (CLK_EN)
    begin
      if (wr_hit && req_r.addr == OSD_OFS_FLT)
        flt_r <= (flt_r & ~HWDATA[OSD_CH-1:0]) | fault_hit;
      else
        flt_r <= flt_r | fault_hit;
    end
  end

  //--------------------------------------------------------------
  // checks
  //--------------------------------------------------------------
  chk_oe_follow: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && ce_low) |=> SPI_SO_OE)
    else $error("serial output not enabled in frame");

  chk_so_tristate: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && !ce_low) |=> !SPI_SO_OE)
    else $error("serial output driven while deselected");

  chk_snap_load: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && ce_fall) |=> snap_r == $past(sense_s_r))
    else $error("sense snapshot not taken at select fall");

  chk_latch_load: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && ce_rise && !pin_rst && !soft_clr)
      |=> DRV_ON == ~word_r)
    else $error("latch does not hold inverted frame word");

  chk_latch_reset: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && pin_rst) |=> DRV_ON == '0)
    else $error("reset pin did not clear latch");

  chk_fault_inhibit: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && ce_rise) |=> (busy_r && !(|fault_hit)) [*8])
    else $error("fault clearing not inhibited after select rise");

  chk_timer_len: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && ce_rise) |=> tmr_r == OSD_TMR_W'(FAULT_DELAY_CYC - 1))
    else $error("inhibit timer loaded with wrong length");

  chk_fault_clear: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && !busy_r && flt_en_r && !ce_rise && !pin_rst && !soft_clr)
      |=> (DRV_ON & $past(sense_s_r)) == '0)
    else $error("faulted channel left on");

  chk_fault_only: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && !ce_rise && !pin_rst && !soft_clr)
      |=> ((DRV_ON ^ $past(DRV_ON)) & ~$past(sense_s_r)) == '0 &&
          (DRV_ON & ~$past(DRV_ON)) == '0)
    else $error("fault touched a healthy channel");

  chk_flag_sticky: assert property (
    @(posedge CLK) disable iff (RST)
    (CLK_EN && |fault_hit) |=> (flt_r & $past(fault_hit)) == $past(fault_hit))
    else $error("fault flag lost");

  chk_so_first: assert property (
    @(posedge SPI_SCLK) disable iff (RST)
    (act_r && !shifted) |-> ##0 1'b1 ##1 (!act_r || SPI_SO == snap_r[OSD_CH-1]))
    else $error("first serial bit is not the top channel");

endmodule

// ---- tb/osd_host_model.sv ----
/*
  host model: drives select, shift clock and serial input as bus master.
  assumes the bench resolves the tri-stated serial output onto so.
*/
`timescale 1ns/10ps
module osd_host_model
(
  // serial link
  output logic     sclk,
  output logic     ce_n,
  output logic     si,
  input  wire logic so
);
  localparam int HALF = 15;
  localparam int LEAD = 300;

  initial
  begin
    sclk = 1'h0;
    ce_n = 1'h1;
    si   = 1'h0;
  end

  // ---------
  // one frame of n bytes, first bit sent is the top one
  // ---------
  task automatic xfer(input int n, input logic [15:0] tx,
                      output logic [15:0] rx);
    #7 ce_n = 1'h0;
    #LEAD;
    for (int i = n * 8 - 1; i >= 0; i--)
    begin
      #HALF sclk = 1'h1;
      si = tx[i];
      #(HALF - 1) rx[i] = so;
      #1 sclk = 1'h0;
    end
    #LEAD ce_n = 1'h1;
    si = ~si;
  endtask

  // shift clock toggled with select high, meant to be ignored
  task automatic stray();
    repeat (4)
    begin
      si = ~si;
      #HALF sclk = 1'h1;
      #HALF sclk = 1'h0;
    end
  endtask
endmodule

// ---- tb/octal_serial_driver_control_bench.sv ----
/*
  self-checking bench of the octal driver control block.
  assumes the host model in osd_host_model and a 40 MHz system clock.
*/
`timescale 1ns/10ps
module octal_serial_driver_control_bench;
  import osd_pkg::*;
  localparam int FD = 20;
  logic        CLK = 1'h0, RST = 1'h1, HSEL = 1'h0, HWRITE = 1'h0;
  logic        RESET_PIN_N = 1'h1, HREADYOUT, HRESP, SCLK, CE_N, SI;
  logic        SO, SO_OE;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, q;
  logic [7:0]  SENSE = 8'h0, DRV_ON;
  logic [15:0] rx;
  wire         so_w = SO_OE ? SO : 1'hz;
  int          error_cnt = 0, check_count = 0;

  always #12.5 CLK = ~CLK;

  osd_ctrl #(.FAULT_DELAY_CYC(FD)) dut (.CLK(CLK), .CLK_EN(1'h1),
    .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
    .SPI_SCLK(SCLK), .SPI_CE_N(CE_N), .SPI_SI(SI), .SPI_SO(SO),
    .SPI_SO_OE(SO_OE), .RESET_PIN_N(RESET_PIN_N), .SENSE(SENSE),
    .DRV_ON(DRV_ON));
  osd_host_model host (.sclk(SCLK), .ce_n(CE_N), .si(SI), .so(so_w));

  // ---------
  // helpers
  // ---------
  task automatic chk(input logic [31:0] got, exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge CLK);
    HSEL <= 1'h1;
    HTRANS <= OSD_HTRANS_NONSEQ;
    HADDR <= a;
    HWRITE <= wr;
    @(posedge CLK);
    while (HREADYOUT !== 1'h1) @(posedge CLK);
    HSEL <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADYOUT !== 1'h1) @(posedge CLK);
    q = HRDATA;
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------
  // scenarios
  // ---------
  task automatic t_reset();
    chk(DRV_ON, 8'h0, "latch");
    chk(SO_OE, 1'h0, "so enable");
    chk(HREADYOUT, 1'h1, "ready");
    chk(HRESP, OSD_HRESP_OKAY, "resp");
  endtask

  task automatic t_frame();
    SENSE <= 8'ha5;
    cyc(3);
    host.xfer(1, 16'h3c, rx);
    chk(rx[7:0], 8'ha5, "diag");
    cyc(1);
    SENSE <= 8'h3c;
    cyc(5);
    chk(DRV_ON, 8'hc3, "latch");
    chk(SO_OE, 1'h0, "so enable");
    ahb(1'h0, 32'(OSD_OFS_DIAG), 32'h0);
    chk(q[15:0], 16'h3ca5, "diag reg");
  endtask

  task automatic t_fault();
    SENSE <= 8'h34;
    cyc(3);
    host.xfer(1, 16'h3c, rx);
    chk(rx[7:0], 8'h34, "open off");
    cyc(1);
    SENSE <= 8'h3d;
    cyc(7);
    chk(DRV_ON, 8'hc3, "inhibit");
    ahb(1'h0, 32'(OSD_OFS_STAT), 32'h0);
    chk(q[9:0], 10'h1c3, "busy");
    cyc(30);
    chk(DRV_ON, 8'hc2, "fault");
    ahb(1'h0, 32'(OSD_OFS_FLT), 32'h0);
    chk(q[7:0], 8'h01, "flags");
  endtask

  task automatic t_chain();
    host.xfer(2, 16'h5a3c, rx);
    chk(rx, 16'h3d5a, "chain");
    cyc(1);
    SENSE <= 8'h3c;
    cyc(5);
    chk(DRV_ON, 8'hc3, "latch");
  endtask

  task automatic t_stray();
    logic so_q;
    so_q = SO;
    host.stray();
    cyc(6);
    chk(SO, so_q, "stray so");
    chk(DRV_ON, 8'hc3, "stray");
    chk(SO_OE, 1'h0, "so enable");
  endtask

  task automatic t_regs();
    ahb(1'h0, 32'(OSD_OFS_STAT), 32'h0);
    chk(q[7:0], 8'hc3, "status");
    ahb(1'h1, 32'(OSD_OFS_FLT), 32'hff);
    ahb(1'h0, 32'(OSD_OFS_FLT), 32'h0);
    chk(q[7:0], 8'h0, "flag clear");
  endtask

  task automatic t_pin();
    RESET_PIN_N <= 1'h0;
    cyc(4);
    RESET_PIN_N <= 1'h1;
    cyc(4);
    chk(DRV_ON, 8'h0, "pin reset");
  endtask

  task automatic t_ctrl();
    ahb(1'h0, 32'(OSD_OFS_CTRL), 32'h0);
    chk(q[1:0], 2'h1, "ctrl reset");
    SENSE <= 8'h00;
    cyc(3);
    host.xfer(1, 16'h0f, rx);
    chk(rx[7:0], 8'h00, "diag low");
    cyc(6);
    chk(DRV_ON, 8'hf0, "latch on");
    ahb(1'h1, 32'(OSD_OFS_CTRL), 32'h2);
    cyc(1);
    chk(DRV_ON, 8'h0, "soft clear");
    ahb(1'h0, 32'(OSD_OFS_CTRL), 32'h0);
    chk(q[1:0], 2'h0, "ctrl write");
  endtask

  initial
  begin
    cyc(6);
    RST <= 1'h0;
    cyc(4);
    t_reset();
    t_frame();
    t_fault();
    t_chain();
    t_stray();
    t_regs();
    t_pin();
    t_ctrl();
    complete_run();
  end

  initial
  begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule
